// >>> shared/jtg_regs.svh
// Constants for the test access port: instruction codes, chain widths.
// Included by the package user files; holds definitions only.
`ifndef JTG_REGS_SVH
`define JTG_REGS_SVH

// Instruction register layout
`define JTG_IR_W 4
`define JTG_IR_CAPTURE 4'h1

// Own instruction codes
`define JTG_OP_EXTEST 4'h0
`define JTG_OP_INTEST 4'h1
`define JTG_OP_SAMPLE 4'h2
`define JTG_OP_IDCODE 4'he
`define JTG_OP_BYPASS 4'hf

// Core debug instruction codes
`define JTG_OP_ABORT 4'h8
`define JTG_OP_DEBUG_PORT_ACCESS_INSTR 4'ha
`define JTG_OP_ACCESS_PORT_ACCESS_INSTR 4'hb

// Data chain widths and capture values
`define JTG_ID_W 32
`define JTG_BSR_W 8
`define JTG_BYPASS_CAPTURE 1'b0

// Levels crossed from the link domain to the system domain
`define JTG_XING_W 5

`endif

// >>> shared/jtg_pkg.sv
// Types shared by the test access port files.
// Assumes nothing of its surroundings.
`default_nettype none
package jtg_pkg;

    // Controller states, sixteen in all
    typedef enum logic [3:0] {
        jtg_tlr, jtg_rti,
        jtg_sdrs, jtg_cdr, jtg_sdr, jtg_e1dr, jtg_pdr, jtg_e2dr, jtg_udr,
        jtg_sirs, jtg_cir, jtg_sir, jtg_e1ir, jtg_pir, jtg_e2ir, jtg_uir
    } jtg_tap_state_type;

    // Data chain chosen by the held instruction
    typedef enum logic [1:0] {
        jtg_dr_bypass, jtg_dr_idcode, jtg_dr_bsr, jtg_dr_core
    } jtg_dr_sel_type;

endpackage
`default_nettype wire

// >>> logic/jtg_sync.sv
// Two-flop synchroniser for a group of independent levels.
// Assumes each bit is a level that holds for several destination clocks.
`timescale 1ns/100ps
`default_nettype none

module jtg_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= '0;
            q <= '0;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// >>> logic/jtg_tap_fsm.sv
// Sixteen-state test access port sequencer, stepped by the mode-select pin.
// Assumes the mode-select pin changes on falling edges of the test clock.
`timescale 1ns/100ps
`default_nettype none

module jtg_tap_fsm (
    input wire logic tck,
    input wire logic tap_rst_n,
    input wire logic tms,
    output var jtg_pkg::jtg_tap_state_type state_reg
);

    jtg_pkg::jtg_tap_state_type state_next;

    // Next state from the sampled mode-select level
    always_comb
    begin
        case (state_reg)
            jtg_pkg::jtg_tlr: state_next = tms ? jtg_pkg::jtg_tlr : jtg_pkg::jtg_rti;
            jtg_pkg::jtg_rti: state_next = tms ? jtg_pkg::jtg_sdrs : jtg_pkg::jtg_rti;
            jtg_pkg::jtg_sdrs: state_next = tms ? jtg_pkg::jtg_sirs : jtg_pkg::jtg_cdr;
            jtg_pkg::jtg_cdr: state_next = tms ? jtg_pkg::jtg_e1dr : jtg_pkg::jtg_sdr;
            jtg_pkg::jtg_sdr: state_next = tms ? jtg_pkg::jtg_e1dr : jtg_pkg::jtg_sdr;
            jtg_pkg::jtg_e1dr: state_next = tms ? jtg_pkg::jtg_udr : jtg_pkg::jtg_pdr;
            jtg_pkg::jtg_pdr: state_next = tms ? jtg_pkg::jtg_e2dr : jtg_pkg::jtg_pdr;
            jtg_pkg::jtg_e2dr: state_next = tms ? jtg_pkg::jtg_udr : jtg_pkg::jtg_sdr;
            jtg_pkg::jtg_udr: state_next = tms ? jtg_pkg::jtg_sdrs : jtg_pkg::jtg_rti;
            jtg_pkg::jtg_sirs: state_next = tms ? jtg_pkg::jtg_tlr : jtg_pkg::jtg_cir;
            jtg_pkg::jtg_cir: state_next = tms ? jtg_pkg::jtg_e1ir : jtg_pkg::jtg_sir;
            jtg_pkg::jtg_sir: state_next = tms ? jtg_pkg::jtg_e1ir : jtg_pkg::jtg_sir;
            jtg_pkg::jtg_e1ir: state_next = tms ? jtg_pkg::jtg_uir : jtg_pkg::jtg_pir;
            jtg_pkg::jtg_pir: state_next = tms ? jtg_pkg::jtg_e2ir : jtg_pkg::jtg_pir;
            jtg_pkg::jtg_e2ir: state_next = tms ? jtg_pkg::jtg_uir : jtg_pkg::jtg_sir;
            jtg_pkg::jtg_uir: state_next = tms ? jtg_pkg::jtg_sdrs : jtg_pkg::jtg_rti;
            default: state_next = jtg_pkg::jtg_tlr;
        endcase
    end

    // Advances on rising test clock only; reset forces the reset state
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            state_reg <= jtg_pkg::jtg_tlr;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

endmodule

`default_nettype wire

// >>> logic/jtg_tap_top.sv
// Test access port with shared serial output toward the core debug port.
// Assumes tck runs at most a quarter of clk, and that core_chain_out is
// the core debug chain's serial bit before its falling-edge retiming.
//
// How it works
// [R01] Standard controller with own and core debug instructions
// [R02] Four-bit instruction register holds current instruction
// [R03] Output multiplexer picks core or own chain
// [R04] Own controller decodes all codes, drives selector
// [R05] State steps only on sampled mode-select level
// [R06] State decides capture, shift, update and chain
// [R07] Held instruction picks the data chain
// [R08] External and internal test leave the boundary chain frozen
// [R09] Unknown codes behave as the bypass bit
// [R10] Low test reset holds the reset state
// [R11] Reset state loads the identity instruction
// [R12] Five high mode-select clocks reach reset state
// [R13] System reset also resets the controller
// [R14] Output released unless a chain shifts out
// [R15] Output changes on falling test clock edge
// [R16] Bypass bit captures zero, delays one clock
`timescale 1ns/100ps
`default_nettype none
`include "jtg_regs.svh"

module jtg_tap_top #(
    parameter logic [`JTG_ID_W-1:0] ID_CODE = 32'h0000_0001 // Arbitrary value
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tms,
    input wire logic tdi,
    input wire logic core_chain_out,
    input wire logic [`JTG_BSR_W-1:0] pin_in,
    output logic tdo,
    output logic tdo_oe,
    output logic core_sel,
    output logic [`JTG_BSR_W-1:0] bsr_drive,
    output logic extest_active,
    output logic intest_active,
    output logic tap_in_reset
);

    // Chain choice for an instruction code
    function automatic jtg_pkg::jtg_dr_sel_type dr_sel_of(input logic [`JTG_IR_W-1:0] op);
        jtg_pkg::jtg_dr_sel_type sel;
        case (op)
            `JTG_OP_IDCODE: sel = jtg_pkg::jtg_dr_idcode;
            `JTG_OP_SAMPLE: sel = jtg_pkg::jtg_dr_bsr;
            `JTG_OP_ABORT: sel = jtg_pkg::jtg_dr_core;
            `JTG_OP_DEBUG_PORT_ACCESS_INSTR: sel = jtg_pkg::jtg_dr_core;
            `JTG_OP_ACCESS_PORT_ACCESS_INSTR: sel = jtg_pkg::jtg_dr_core;
            default: sel = jtg_pkg::jtg_dr_bypass;
        endcase
        return sel;
    endfunction

    // Link domain state
    jtg_pkg::jtg_tap_state_type state_reg;
    logic [1:0] por_tck_reg;
    logic [`JTG_IR_W-1:0] ir_shift_reg, ir_reg;
    logic bypass_reg, upd_tgl_reg, hold_reg, extest_reg, intest_reg, tlr_reg;
    logic [`JTG_ID_W-1:0] id_shift_reg;
    logic [`JTG_BSR_W-1:0] bsr_shift_reg, bsr_par_reg;

    // System domain state
    logic [`JTG_BSR_W-1:0] pin_sync, snap_reg;
    logic [`JTG_XING_W-1:0] xing_sync;
    logic upd_seen_reg;

    // Decoded wires
    wire tap_rst_n, in_tlr, shifting, dr_out, tdo_next, upd_new;
    wire cap_dr, shf_dr, upd_dr, cap_ir, shf_ir, upd_ir;
    wire [`JTG_BSR_W-1:0] bsr_shift_next;
    wire [`JTG_IR_W-1:0] ir_next;
    wire hold_sync, extest_sync, intest_sync, upd_sync, tlr_sync;
    jtg_pkg::jtg_dr_sel_type dr_sel, dr_sel_upd;

    // Either reset forces the controller; system reset released on tck
    assign tap_rst_n = trst_n & por_tck_reg[1]; // [R10] [R13]

    // System reset enters the link domain asynchronously
    always_ff @(posedge tck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_tck_reg <= 2'h0; // [R13]
        end
        else
        begin
            por_tck_reg <= {por_tck_reg[0], 1'b1};
        end
    end

    // Sequencer; five high mode-select clocks always end in reset state
    jtg_tap_fsm u_fsm (
        .tck(tck),
        .tap_rst_n(tap_rst_n),
        .tms(tms), // [R05] [R12]
        .state_reg(state_reg)
    );

    // State decodes steering the chains
    assign in_tlr = (state_reg == jtg_pkg::jtg_tlr);
    assign cap_dr = (state_reg == jtg_pkg::jtg_cdr); // [R06]
    assign shf_dr = (state_reg == jtg_pkg::jtg_sdr); // [R06]
    assign upd_dr = (state_reg == jtg_pkg::jtg_udr); // [R06]
    assign cap_ir = (state_reg == jtg_pkg::jtg_cir); // [R06]
    assign shf_ir = (state_reg == jtg_pkg::jtg_sir); // [R06]
    assign upd_ir = (state_reg == jtg_pkg::jtg_uir); // [R06]
    assign shifting = shf_dr | shf_ir;

    // Held instruction picks the chain; unknown codes fall to bypass
    assign dr_sel = dr_sel_of(ir_reg); // [R07] [R09] [R04]
    // Selector as it will be after a pending instruction update
    assign dr_sel_upd = upd_ir ? dr_sel_of(ir_shift_reg) : dr_sel; // [R04]
    // Instruction in effect after this edge; flags use it so they need no extra clock
    assign ir_next = in_tlr ? `JTG_OP_IDCODE : upd_ir ? ir_shift_reg : ir_reg; // [R11] [R02]

    // Instruction chain: capture fixed pattern, shift toward tdo
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            ir_shift_reg <= `JTG_IR_CAPTURE;
        end
        else if (cap_ir)
        begin
            ir_shift_reg <= `JTG_IR_CAPTURE;
        end
        else if (shf_ir)
        begin
            ir_shift_reg <= {tdi, ir_shift_reg[`JTG_IR_W-1:1]}; // [R02]
        end
    end

    // Instruction in effect; identity instruction in reset state
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            ir_reg <= `JTG_OP_IDCODE; // [R11]
        end
        else
        begin
            ir_reg <= ir_next; // [R02] [R11]
        end
    end

    // Bypass bit: zero on capture, one clock of delay on shift
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            bypass_reg <= `JTG_BYPASS_CAPTURE;
        end
        else if (cap_dr && dr_sel == jtg_pkg::jtg_dr_bypass)
        begin
            bypass_reg <= `JTG_BYPASS_CAPTURE; // [R16]
        end
        else if (shf_dr && dr_sel == jtg_pkg::jtg_dr_bypass)
        begin
            bypass_reg <= tdi; // [R16] [R09]
        end
    end

    // Identity chain
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            id_shift_reg <= ID_CODE;
        end
        else if (cap_dr && dr_sel == jtg_pkg::jtg_dr_idcode)
        begin
            id_shift_reg <= ID_CODE; // [R07]
        end
        else if (shf_dr && dr_sel == jtg_pkg::jtg_dr_idcode)
        begin
            id_shift_reg <= {tdi, id_shift_reg[`JTG_ID_W-1:1]}; // [R07]
        end
    end

    // Boundary chain shift path, one stage per cell
    genvar gi;
    generate
        for (gi = 0; gi < `JTG_BSR_W; gi = gi + 1)
        begin : g_bsr
            if (gi == `JTG_BSR_W - 1)
            begin : g_top
                assign bsr_shift_next[gi] = tdi;
            end
            else
            begin : g_mid
                assign bsr_shift_next[gi] = bsr_shift_reg[gi+1];
            end
        end
    endgenerate

    // Boundary chain moves only under sample/preload
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            bsr_shift_reg <= '0;
        end
        else if (cap_dr && dr_sel == jtg_pkg::jtg_dr_bsr)
        begin
            bsr_shift_reg <= snap_reg; // [R07]
        end
        else if (shf_dr && dr_sel == jtg_pkg::jtg_dr_bsr)
        begin
            bsr_shift_reg <= bsr_shift_next; // [R07] [R08]
        end
    end

    // Boundary parallel word and its update toggle
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            bsr_par_reg <= '0;
            upd_tgl_reg <= 1'b0;
        end
        else if (upd_dr && dr_sel == jtg_pkg::jtg_dr_bsr)
        begin
            bsr_par_reg <= bsr_shift_reg; // [R07] [R08]
            upd_tgl_reg <= ~upd_tgl_reg;
        end
    end

    // Freeze the pin snapshot from select until capture is done
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            hold_reg <= 1'b0;
        end
        else
        begin
            hold_reg <= (state_reg == jtg_pkg::jtg_sdrs) | cap_dr;
        end
    end

    // Test modes act on the word already in the chain
    always_ff @(posedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            extest_reg <= 1'b0;
            intest_reg <= 1'b0;
            tlr_reg <= 1'b1;
        end
        else
        begin
            extest_reg <= (ir_next == `JTG_OP_EXTEST); // [R08] [R01]
            intest_reg <= (ir_next == `JTG_OP_INTEST); // [R08] [R01]
            // Reset flag tracks the state being entered; tck may stop right after
            tlr_reg <= tms & (in_tlr | (state_reg == jtg_pkg::jtg_sirs)); // [R12]
        end
    end

    // Serial bit of the own chain in use
    assign dr_out = (dr_sel == jtg_pkg::jtg_dr_idcode) ? id_shift_reg[0] :
        (dr_sel == jtg_pkg::jtg_dr_bsr) ? bsr_shift_reg[0] : bypass_reg; // [R09]

    // Output multiplexer: core chain under core debug codes
    assign tdo_next = shf_ir ? ir_shift_reg[0] :
        (dr_sel == jtg_pkg::jtg_dr_core) ? core_chain_out : dr_out; // [R03]

    // Output retimed on the falling edge, released when idle
    always_ff @(negedge tck or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0; // [R14]
            core_sel <= 1'b0;
        end
        else
        begin
            tdo <= shifting ? tdo_next : 1'b0; // [R15] [R03]
            tdo_oe <= shifting; // [R14] [R15]
            core_sel <= (dr_sel_upd == jtg_pkg::jtg_dr_core); // [R04]
        end
    end

    // Pins reach the snapshot through two flops
    jtg_sync #(
        .W(`JTG_BSR_W)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pin_in),
        .q(pin_sync)
    );

    // Levels from the link domain
    jtg_sync #(
        .W(`JTG_XING_W)
    ) u_xing_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({tlr_reg, upd_tgl_reg, intest_reg, extest_reg, hold_reg}),
        .q(xing_sync)
    );

    assign hold_sync = xing_sync[0];
    assign extest_sync = xing_sync[1];
    assign intest_sync = xing_sync[2];
    assign upd_sync = xing_sync[3];
    assign tlr_sync = xing_sync[4];
    assign upd_new = upd_sync ^ upd_seen_reg;

    // Snapshot stands still while the link side may capture it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            snap_reg <= '0;
        end
        else if (!hold_sync)
        begin
            snap_reg <= pin_sync;
        end
    end

    // Take the boundary word when its toggle arrives
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upd_seen_reg <= 1'b0;
            bsr_drive <= '0;
        end
        else
        begin
            upd_seen_reg <= upd_sync;
            if (upd_new)
            begin
                bsr_drive <= bsr_par_reg; // [R08]
            end
        end
    end

    // Mode levels toward the pin logic
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extest_active <= 1'b0;
            intest_active <= 1'b0;
            tap_in_reset <= 1'b1;
        end
        else
        begin
            extest_active <= extest_sync; // [R08]
            intest_active <= intest_sync; // [R08]
            tap_in_reset <= tlr_sync;
        end
    end

endmodule

`default_nettype wire

// >>> dv/jtg_tap_props.sv
// Checker on the test access port outputs.
// Assumes test clock edges never meet system clock edges.
`timescale 1ns/100ps
`default_nettype none
`include "jtg_regs.svh"
module jtg_tap_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic core_sel,
    input wire logic [`JTG_BSR_W-1:0] bsr_drive,
    input wire logic extest_active,
    input wire logic intest_active,
    input wire logic tap_in_reset
);
    // All checks sampled on the system clock
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_trst_quiet: assert property (
        !trst_n |-> !tdo_oe && !core_sel) else $error("Port active in test reset");
    a_tdo_released: assert property (
        !tdo_oe |-> !tdo) else $error("Serial out not idle");
    a_tdo_on_fall: assert property (disable iff (!rst_n || !trst_n)
        $changed(tdo) || $changed(tdo_oe) |-> !tck) else $error("Serial out moved high");
    a_reset_ir_own: assert property (
        tap_in_reset [*8] |-> !core_sel) else $error("Core chain chosen in reset");
    a_oe_not_reset: assert property (
        tdo_oe |-> !tap_in_reset) else $error("Shifting during reset");
    a_extest_frozen: assert property (
        extest_active && $past(extest_active) |-> $stable(bsr_drive))
        else $error("Boundary word moved");
    a_intest_frozen: assert property (
        intest_active && $past(intest_active) |-> $stable(bsr_drive))
        else $error("Boundary word moved");
    a_one_mode: assert property (
        !(extest_active && intest_active)) else $error("Two test modes");
    a_post_reset: assert property (
        !$past(rst_n) |-> tap_in_reset && bsr_drive == '0) else $error("Reset values lost");
endmodule
bind jtg_tap_top jtg_tap_props u_props (
    .clk(clk),
    .rst_n(rst_n),
    .tck(tck),
    .trst_n(trst_n),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .core_sel(core_sel),
    .bsr_drive(bsr_drive),
    .extest_active(extest_active),
    .intest_active(intest_active),
    .tap_in_reset(tap_in_reset)
);
`default_nettype wire

// >>> dv/jtg_tap_probe.sv
// Model of the external test controller on the link pins.
// Assumes a pull-up on the serial output line.
`timescale 1ns/100ps
`default_nettype none
module jtg_tap_probe (
    output var logic tck,
    output var logic tms,
    output var logic tdi,
    output var logic trst_n,
    input wire logic tdo,
    input wire logic tdo_oe
);
    wire logic line;
    // Released line rests high
    assign line = tdo_oe ? tdo : 1'b1;
    // Clock stopped low, test reset held
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b0;
    end
    task automatic set_trst(input logic v);
        trst_n = v;
    endtask
    // One clock; pins move while low, line taken at the rise
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #80 tck = 1'b1;
        o = line;
        #80 tck = 1'b0;
    endtask
    // From idle to a shift state
    task automatic enter(input logic ir);
        logic b;
        step(1'b1, 1'b0, b);
        if (ir)
            step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    // Whole scan back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] d,
        output logic [31:0] q);
        logic b;
        enter(ir);
        q = '0;
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
    // Leave reset, then idle
    task automatic wake();
        logic b;
        step(1'b1, 1'b0, b);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the test access port.
// Assumes the probe drives the link pins, the bench the system side.
`timescale 1ns/100ps
`default_nettype none
`include "jtg_regs.svh"
module testbench;
    localparam logic [31:0] ID = 32'h5a0f_3c01; // Arbitrary value
    localparam int LIMIT = 40000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic core_chain_out = 1'b0;
    logic [`JTG_BSR_W-1:0] pin_in = 8'h00;
    wire logic tck, tms, tdi, trst_n, tdo, tdo_oe, core_sel;
    wire logic extest_active, intest_active, tap_in_reset;
    wire logic [`JTG_BSR_W-1:0] bsr_drive;
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] q;
    logic b;
    jtg_tap_top #(.ID_CODE(ID)) uut (.clk(clk), .rst_n(rst_n), .tck(tck),
        .trst_n(trst_n), .tms(tms), .tdi(tdi), .core_chain_out(core_chain_out),
        .pin_in(pin_in), .tdo(tdo), .tdo_oe(tdo_oe), .core_sel(core_sel),
        .bsr_drive(bsr_drive), .extest_active(extest_active),
        .intest_active(intest_active), .tap_in_reset(tap_in_reset));
    jtg_tap_probe u_probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
        .tdo(tdo), .tdo_oe(tdo_oe));
    // System clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic wclk(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic load(input logic [3:0] code);
        u_probe.scan(1'b1, 4, {28'h0, code}, q);
        check(q, {28'h0, `JTG_IR_CAPTURE});
    endtask
    task automatic t_idcode();
        u_probe.scan(1'b0, 32, 32'h0, q);
        check(q, ID);
    endtask
    task automatic t_bypass();
        logic [3:0] codes [9] = '{4'hf, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hc, 4'hd};
        foreach (codes[i])
        begin
            load(codes[i]);
            check(core_sel, 1'b0);
            u_probe.scan(1'b0, 8, 32'h5a, q);
            check(q, 32'hb4);
        end
    endtask
    task automatic t_core();
        logic [3:0] codes [3] = '{4'h8, 4'ha, 4'hb};
        wclk(1);
        core_chain_out = 1'b1;
        foreach (codes[i])
        begin
            load(codes[i]);
            check(core_sel, 1'b1);
            u_probe.scan(1'b0, 4, 32'h0, q);
            check(q, 32'hf);
        end
        load(`JTG_OP_IDCODE);
        check(core_sel, 1'b0);
        t_idcode();
    endtask
    task automatic t_sample();
        wclk(1);
        pin_in = 8'ha5;
        load(`JTG_OP_SAMPLE);
        u_probe.scan(1'b0, 8, 32'h3c, q);
        check(q, 32'ha5);
        wclk(6);
        check(bsr_drive, 32'h3c);
    endtask
    task automatic t_modes();
        load(`JTG_OP_EXTEST);
        wclk(5);
        check({extest_active, intest_active}, 2'b10);
        u_probe.scan(1'b0, 8, 32'h5a, q);
        check(q, 32'hb4);
        load(`JTG_OP_INTEST);
        wclk(5);
        check({extest_active, intest_active}, 2'b01);
        u_probe.scan(1'b0, 8, 32'h5a, q);
        check(q, 32'hb4);
        check(bsr_drive, 32'h3c);
    endtask
    task automatic t_tms_reset();
        u_probe.enter(1'b0);
        repeat (4) u_probe.step(1'b1, 1'b0, b);
        wclk(6);
        check(tap_in_reset, 1'b0);
        u_probe.step(1'b1, 1'b0, b);
        wclk(6);
        check(tap_in_reset, 1'b1);
        u_probe.step(1'b0, 1'b0, b);
        t_idcode();
    endtask
    task automatic t_trst();
        load(`JTG_OP_SAMPLE);
        u_probe.enter(1'b0);
        // Enable is launched by the same falling edge that ends enter
        wclk(2);
        check(tdo_oe, 1'b1);
        u_probe.set_trst(1'b0);
        #1;
        check(tdo_oe, 1'b0);
        u_probe.step(1'b0, 1'b0, b);
        wclk(6);
        check(tap_in_reset, 1'b1);
        u_probe.set_trst(1'b1);
        u_probe.wake();
        t_idcode();
    endtask
    task automatic t_rst();
        load(4'hb);
        wclk(1);
        rst_n = 1'b0;
        wclk(4);
        check({bsr_drive, extest_active, intest_active, tap_in_reset}, 11'h001);
        check(core_sel, 1'b0);
        rst_n = 1'b1;
        u_probe.wake();
        t_idcode();
    endtask
    // Main sequence; reset spans five rising clock edges
    initial
    begin
        wclk(5);
        rst_n = 1'b1;
        u_probe.set_trst(1'b1);
        check(tap_in_reset, 1'b1);
        u_probe.wake();
        t_idcode();
        t_bypass();
        t_core();
        t_sample();
        t_modes();
        t_tms_reset();
        t_trst();
        t_rst();
        summarize();
    end
endmodule
`default_nettype wire
